// File: crou_pkg.sv
package crou_pkg;
  localparam int CROU_W = 16;
  localparam int CROU_NREG = 16;
  localparam logic [3:0] CROU_IDX_PC = 4'h0;
  localparam logic [3:0] CROU_IDX_SP = 4'h1;
  localparam logic [3:0] CROU_IDX_SR = 4'h2;
  localparam logic [3:0] CROU_IDX_CG = 4'h3;
  localparam int CROU_SR_C = 0;
  localparam int CROU_SR_Z = 1;
  localparam int CROU_SR_N = 2;
  localparam int CROU_SR_GIE = 3;
  localparam int CROU_SR_HALT = 4;
  localparam int CROU_SR_CSTOP = 5;
  localparam int CROU_SR_V = 8;
  localparam logic [15:0] CROU_RST_VAL = 16'h0000;
  localparam logic [15:0] CROU_K0 = 16'h0000;
  localparam logic [15:0] CROU_K1 = 16'h0001;
  localparam logic [15:0] CROU_K2 = 16'h0002;
  localparam logic [15:0] CROU_K4 = 16'h0004;
  localparam logic [15:0] CROU_K8 = 16'h0008;
  localparam logic [15:0] CROU_KM1 = 16'hFFFF;
  localparam logic [15:0] CROU_STEP_B = 16'h0001;
  localparam logic [15:0] CROU_STEP_W = 16'h0002;
  typedef enum logic [1:0] {
    CROU_AM_REG = 2'h0,
    CROU_AM_IDX = 2'h1,
    CROU_AM_IND = 2'h2,
    CROU_AM_INC = 2'h3
  } crou_amode_t;
  typedef enum logic [1:0] {
    CROU_LEN2 = 2'h1,
    CROU_LEN4 = 2'h2,
    CROU_LEN6 = 2'h3
  } crou_len_t;
endpackage : crou_pkg

// File: crou_regfile.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module crou_regfile
  import crou_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] src_reg,
  input wire logic [1:0] source_mode_bits,
  input wire logic [3:0] dst_reg,
  input wire logic dst_mode,
  input wire logic byte_op,
  input wire logic [15:0] ext_word,
  input wire logic pc_adv,
  input wire crou_len_t pc_len,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_val,
  input wire logic src_upd,
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  input wire logic sp_push,
  input wire logic sp_pop,
  input wire logic flag_upd,
  input wire logic [16:0] alu_sum,
  input wire logic alu_ovf,
  input wire logic irq_req,
  input wire logic test_select_pin,
  input wire logic [3:0] gpio_dbg_in,
  output logic [15:0] src_operand_r,
  output logic [15:0] src_addr_r,
  output logic src_is_const_r,
  output logic [15:0] dst_addr_r,
  output logic [15:0] program_counter_r,
  output logic [15:0] stack_pointer_r,
  output logic [15:0] status_word_r,
  output logic core_clk_en_r,
  output logic exec_en_r,
  output logic irq_accept_r,
  output logic dbg_active_r,
  output logic [3:0] dbg_pins_r
);
  //////////////////////////////////////////////////////////////////////////////
  logic [15:0] gpr_r [4:15];
  logic tsel_m_r;
  logic tsel_s_r;
  logic [3:0] dbg_m_r;
  logic [3:0] dbg_s_r;
  logic [15:0] pc_nxt;
  logic [15:0] sp_nxt;
  logic [15:0] sr_nxt;
  logic [15:0] src_val;
  logic [15:0] src_nxt;
  logic const_sel;
  logic [15:0] wr_val;

  function automatic logic [15:0] rd_reg(input logic [3:0] idx, input logic [15:0] pc,
                                         input logic [15:0] sp, input logic [15:0] sr,
                                         input logic [15:0] g);
    logic [15:0] v;
    v = g;
    case (idx)
      CROU_IDX_PC: v = pc;
      CROU_IDX_SP: v = sp;
      CROU_IDX_SR: v = sr;
      CROU_IDX_CG: v = CROU_K0;
      default: v = g;
    endcase
    return v;
  endfunction : rd_reg

  function automatic logic [15:0] step_of(input logic b);
    return b ? CROU_STEP_B : CROU_STEP_W;
  endfunction : step_of

  //////////////////////////////////////////////////////////////////////////////
  // operand decode
  always_comb begin
    src_val = rd_reg(src_reg, program_counter_r, stack_pointer_r, status_word_r,
                     (src_reg >= 4'h4) ? gpr_r[src_reg] : CROU_K0);
    const_sel = 1'b0;
    src_nxt = src_val;
    if (src_reg == CROU_IDX_SR) begin
      if (source_mode_bits == CROU_AM_REG && !byte_op) begin
        src_nxt = status_word_r;
      end else begin
        const_sel = (source_mode_bits != CROU_AM_IDX);
        case (source_mode_bits)
          CROU_AM_IDX: src_nxt = CROU_K0;
          CROU_AM_IND: src_nxt = CROU_K4;
          CROU_AM_INC: src_nxt = CROU_K8;
          default: src_nxt = CROU_K0;
        endcase
        if (source_mode_bits == CROU_AM_REG) begin
          const_sel = 1'b1;
        end
      end
    end else if (src_reg == CROU_IDX_CG) begin
      const_sel = 1'b1;
      case (source_mode_bits)
        CROU_AM_REG: src_nxt = CROU_K0;
        CROU_AM_IDX: src_nxt = CROU_K1;
        CROU_AM_IND: src_nxt = CROU_K2;
        CROU_AM_INC: src_nxt = CROU_KM1;
        default: src_nxt = CROU_K0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      src_operand_r <= CROU_RST_VAL;
      src_addr_r <= CROU_RST_VAL;
      src_is_const_r <= 1'b0;
      dst_addr_r <= CROU_RST_VAL;
    end else begin
      src_is_const_r <= const_sel;
      src_operand_r <= byte_op ? {8'h00, src_nxt[7:0]} : src_nxt;
      case (source_mode_bits)
        CROU_AM_IDX: src_addr_r <= src_nxt + ext_word;
        CROU_AM_IND: src_addr_r <= src_val;
        CROU_AM_INC: src_addr_r <= src_val;
        default: src_addr_r <= src_val;
      endcase
      dst_addr_r <= dst_mode ? (((dst_reg == CROU_IDX_SR) ? CROU_K0 :
                    rd_reg(dst_reg, program_counter_r, stack_pointer_r, status_word_r,
                    (dst_reg >= 4'h4) ? gpr_r[dst_reg] : CROU_K0)) + ext_word)
                    : CROU_K0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // program counter
  always_comb begin
    pc_nxt = program_counter_r;
    if (pc_load) begin
      pc_nxt = pc_load_val;
    end else if (wr_en && dst_reg == CROU_IDX_PC) begin
      pc_nxt = wr_data;
    end else if (src_upd && src_reg == CROU_IDX_PC && source_mode_bits == CROU_AM_INC) begin
      pc_nxt = program_counter_r + CROU_STEP_W;
    end else if (pc_adv) begin
      pc_nxt = program_counter_r + {13'h0000, pc_len, 1'b0};
    end
    pc_nxt[0] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_counter_r <= CROU_RST_VAL;
    end else if (exec_en_r) begin
      program_counter_r <= pc_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // stack pointer
  always_comb begin
    sp_nxt = stack_pointer_r;
    if (sp_push) begin
      sp_nxt = stack_pointer_r - CROU_STEP_W;
    end else if (sp_pop) begin
      sp_nxt = stack_pointer_r + CROU_STEP_W;
    end else if (wr_en && dst_reg == CROU_IDX_SP) begin
      sp_nxt = wr_data;
    end else if (src_upd && src_reg == CROU_IDX_SP && source_mode_bits == CROU_AM_INC) begin
      sp_nxt = stack_pointer_r + step_of(byte_op);
    end
    sp_nxt[0] = 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stack_pointer_r <= CROU_RST_VAL;
    end else if (exec_en_r) begin
      stack_pointer_r <= sp_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status word
  always_comb begin
    sr_nxt = status_word_r;
    if (wr_en && dst_reg == CROU_IDX_SR && !dst_mode && !byte_op) begin
      sr_nxt = wr_data;
    end
    if (flag_upd) begin
      sr_nxt[CROU_SR_V] = alu_ovf;
      sr_nxt[CROU_SR_N] = byte_op ? alu_sum[7] : alu_sum[15];
      sr_nxt[CROU_SR_Z] = byte_op ? (alu_sum[7:0] == 8'h00)
                                  : (alu_sum[15:0] == 16'h0000);
      sr_nxt[CROU_SR_C] = byte_op ? alu_sum[8] : alu_sum[16];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_word_r <= CROU_RST_VAL;
    end else if (exec_en_r) begin
      status_word_r <= sr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // general registers
  always_comb begin
    wr_val = wr_data;
    if (byte_op) begin
      wr_val = {8'h00, wr_data[7:0]};
    end
  end

  genvar gi;
  generate
    for (gi = 4; gi < CROU_NREG; gi++) begin : g_gpr
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          gpr_r[gi] <= CROU_RST_VAL;
        end else if (exec_en_r) begin
          if (wr_en && dst_reg == 4'(gi)) begin
            gpr_r[gi] <= wr_val;
          end else if (src_upd && src_reg == 4'(gi) && source_mode_bits == CROU_AM_INC) begin
            gpr_r[gi] <= gpr_r[gi] + step_of(byte_op);
          end
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // power modes and interrupt gate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_clk_en_r <= 1'b1;
      exec_en_r <= 1'b1;
      irq_accept_r <= 1'b0;
    end else begin
      if (exec_en_r) begin
        core_clk_en_r <= !sr_nxt[CROU_SR_CSTOP];
        exec_en_r <= !sr_nxt[CROU_SR_HALT] && !sr_nxt[CROU_SR_CSTOP];
      end
      irq_accept_r <= irq_req && status_word_r[CROU_SR_GIE];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // debug access
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tsel_m_r <= 1'b0;
      tsel_s_r <= 1'b0;
      dbg_m_r <= 4'h0;
      dbg_s_r <= 4'h0;
    end else begin
      tsel_m_r <= test_select_pin;
      tsel_s_r <= tsel_m_r;
      dbg_m_r <= gpio_dbg_in;
      dbg_s_r <= dbg_m_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_active_r <= 1'b0;
      dbg_pins_r <= 4'h0;
    end else if (!tsel_s_r) begin
      dbg_active_r <= 1'b0;
      dbg_pins_r <= 4'h0;
    end else begin
      dbg_active_r <= 1'b1;
      dbg_pins_r <= dbg_s_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  pc_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    !program_counter_r[0]) else $error("pc odd");
  sp_align_a: assert property (@(posedge clk) disable iff (!rst_n)
    !stack_pointer_r[0]) else $error("sp odd");
  pc_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && pc_adv && !pc_load && !wr_en && !src_upd |=>
    program_counter_r == $past(program_counter_r) + {13'h0000, $past(pc_len), 1'b0})
    else $error("pc step wrong");
  sp_push_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && sp_push |=> stack_pointer_r == $past(stack_pointer_r) - 16'h0002)
    else $error("push wrong");
  sp_pop_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && sp_pop && !sp_push |=> stack_pointer_r == $past(stack_pointer_r) + 16'h0002)
    else $error("pop wrong");
  cg_r3_a: assert property (@(posedge clk) disable iff (!rst_n)
    src_reg == CROU_IDX_CG && source_mode_bits == CROU_AM_INC && !byte_op
    |=> src_operand_r == 16'hFFFF && src_is_const_r) else $error("r3 const");
  cg_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    src_reg == CROU_IDX_CG && source_mode_bits == CROU_AM_IDX
    |=> src_operand_r == 16'h0001) else $error("r3 one");
  cg_r2_a: assert property (@(posedge clk) disable iff (!rst_n)
    src_reg == CROU_IDX_SR && source_mode_bits == CROU_AM_IND
    |=> src_operand_r == 16'h0004) else $error("r2 const");
  sr_byte_wr_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && wr_en && byte_op && dst_reg == CROU_IDX_SR && !flag_upd
    |=> $stable(status_word_r)) else $error("sr byte write");
  zero_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && flag_upd && !byte_op && alu_sum[15:0] == 16'h0000
    |=> status_word_r[1]) else $error("zero flag");
  carry_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec_en_r && flag_upd && byte_op |=> status_word_r[0] == $past(alu_sum[8]))
    else $error("carry flag");
  halt_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !exec_en_r |=> !exec_en_r && $stable(program_counter_r))
    else $error("halt not held");
  dst_reg_mode_a: assert property (@(posedge clk) disable iff (!rst_n)
    !dst_mode |=> dst_addr_r == 16'h0000) else $error("dst addr in register mode");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    irq_accept_r |-> $past(status_word_r[3])) else $error("irq gate");
  dbg_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tsel_s_r |=> !dbg_active_r && dbg_pins_r == 4'h0) else $error("dbg reset");
  cov_push_c: cover property (@(posedge clk) disable iff (!rst_n) exec_en_r && sp_push);
  cov_imm_c: cover property (@(posedge clk) disable iff (!rst_n)
    src_upd && src_reg == CROU_IDX_PC && source_mode_bits == CROU_AM_INC);
  cov_halt_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(exec_en_r));
  cov_dbg_c: cover property (@(posedge clk) disable iff (!rst_n) $rose(dbg_active_r));
endmodule : crou_regfile

// File: crou_alu_model.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// far-side adder of the core: sum with carry out and signed overflow
module crou_alu_model
  import crou_pkg::*;
(
  input wire logic [15:0] op_a,
  input wire logic [15:0] op_b,
  input wire logic byte_op,
  output logic [16:0] alu_sum,
  output logic alu_ovf
);
  always_comb begin
    if (byte_op) begin
      alu_sum = {8'h00, {1'b0, op_a[7:0]} + {1'b0, op_b[7:0]}};
      alu_ovf = (op_a[7] == op_b[7]) && (alu_sum[7] != op_a[7]);
    end else begin
      alu_sum = {1'b0, op_a} + {1'b0, op_b};
      alu_ovf = (op_a[15] == op_b[15]) && (alu_sum[15] != op_a[15]);
    end
  end
endmodule : crou_alu_model

// File: cpu_register_operand_unit_test.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module cpu_register_operand_unit_test;
  import crou_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] src_reg = 4'h0, dst_reg = 4'h0, gpio_dbg_in = 4'hA;
  logic [1:0] source_mode_bits = 2'h0;
  logic dst_mode = 1'b0, byte_op = 1'b0, pc_adv = 1'b0, pc_load = 1'b0, src_upd = 1'b0;
  logic wr_en = 1'b0, sp_push = 1'b0, sp_pop = 1'b0, flag_upd = 1'b0, irq_req = 1'b0;
  logic test_select_pin = 1'b0;
  logic [15:0] ext_word = 16'h0000, pc_load_val = 16'h0000, wr_data = 16'h0000;
  logic [15:0] op_a = 16'h0000, op_b = 16'h0000;
  crou_len_t pc_len = CROU_LEN2;
  logic [16:0] alu_sum;
  logic alu_ovf, src_is_const_r, core_clk_en_r, exec_en_r, irq_accept_r, dbg_active_r;
  logic [15:0] src_operand_r, src_addr_r, dst_addr_r, program_counter_r;
  logic [15:0] stack_pointer_r, status_word_r;
  logic [3:0] dbg_pins_r;
  logic [15:0] k3 [4] = '{16'h0000, 16'h0001, 16'h0002, 16'hFFFF};
  int fails = 0;
  int compares = 0;

  always #25 clk = ~clk;

  crou_alu_model crou_alu_model_inst (.op_a(op_a), .op_b(op_b), .byte_op(byte_op),
    .alu_sum(alu_sum), .alu_ovf(alu_ovf));

  crou_regfile crou_regfile_inst (.clk(clk), .rst_n(rst_n), .src_reg(src_reg),
    .source_mode_bits(source_mode_bits), .dst_reg(dst_reg), .dst_mode(dst_mode),
    .byte_op(byte_op), .ext_word(ext_word), .pc_adv(pc_adv), .pc_len(pc_len),
    .pc_load(pc_load), .pc_load_val(pc_load_val), .src_upd(src_upd), .wr_en(wr_en),
    .wr_data(wr_data), .sp_push(sp_push), .sp_pop(sp_pop), .flag_upd(flag_upd),
    .alu_sum(alu_sum), .alu_ovf(alu_ovf), .irq_req(irq_req),
    .test_select_pin(test_select_pin), .gpio_dbg_in(gpio_dbg_in),
    .src_operand_r(src_operand_r), .src_addr_r(src_addr_r),
    .src_is_const_r(src_is_const_r), .dst_addr_r(dst_addr_r),
    .program_counter_r(program_counter_r), .stack_pointer_r(stack_pointer_r),
    .status_word_r(status_word_r), .core_clk_en_r(core_clk_en_r),
    .exec_en_r(exec_en_r), .irq_accept_r(irq_accept_r),
    .dbg_active_r(dbg_active_r), .dbg_pins_r(dbg_pins_r));

  //////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic cmp(input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp

  task automatic do_reset;
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
  endtask : do_reset

  task automatic rd(input logic [3:0] r, input logic [1:0] m, input logic b,
                    input logic [15:0] x);
    src_reg = r;
    source_mode_bits = m;
    byte_op = b;
    ext_word = x;
    @(negedge clk);
  endtask : rd

  task automatic wr(input logic [3:0] r, input logic [15:0] d, input logic b);
    dst_reg = r;
    byte_op = b;
    wr_data = d;
    wr_en = 1'b1;
    @(negedge clk);
    wr_en = 1'b0;
    @(negedge clk);
  endtask : wr

  task automatic flg(input logic [15:0] a, input logic [15:0] b, input logic bop);
    op_a = a;
    op_b = b;
    byte_op = bop;
    flag_upd = 1'b1;
    @(negedge clk);
    flag_upd = 1'b0;
    @(negedge clk);
  endtask : flg

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    fails++;
    print_verdict();
  end

  initial begin
    do_reset();
    cmp(16'h0000, status_word_r);
    cmp(16'h0000, program_counter_r);
    cmp(16'h0003, {14'h0, core_clk_en_r, exec_en_r});
    for (int i = 0; i < 4; i++) begin
      rd(CROU_IDX_CG, i[1:0], 1'b0, 16'h0000);
      cmp(k3[i], src_operand_r);
      cmp(16'h0001, {15'h0, src_is_const_r});
    end
    rd(CROU_IDX_SR, 2'h2, 1'b0, 16'h0000);
    cmp(16'h0004, src_operand_r);
    rd(CROU_IDX_SR, 2'h3, 1'b0, 16'h0000);
    cmp(16'h0008, src_operand_r);
    rd(CROU_IDX_SR, 2'h1, 1'b0, 16'h0040);
    cmp(16'h0040, src_addr_r);
    pc_adv = 1'b1;
    for (int i = 1; i < 4; i++) begin
      pc_len = crou_len_t'(i[1:0]);
      @(negedge clk);
      cmp(16'(i * (i + 1)), program_counter_r);
    end
    pc_adv = 1'b0;
    pc_load_val = 16'h1234;
    pc_load = 1'b1;
    @(negedge clk);
    pc_load = 1'b0;
    rd(CROU_IDX_PC, 2'h3, 1'b0, 16'h0000);
    src_upd = 1'b1;
    @(negedge clk);
    src_upd = 1'b0;
    cmp(16'h1236, program_counter_r);
    wr(CROU_IDX_SP, 16'h0401, 1'b0);
    cmp(16'h0400, stack_pointer_r);
    sp_push = 1'b1;
    @(negedge clk);
    sp_push = 1'b0;
    cmp(16'h03FE, stack_pointer_r);
    sp_pop = 1'b1;
    @(negedge clk);
    sp_pop = 1'b0;
    cmp(16'h0400, stack_pointer_r);
    wr(4'h5, 16'hA5C3, 1'b0);
    wr(4'h6, 16'h1234, 1'b1);
    wr(CROU_IDX_CG, 16'h5555, 1'b0);
    rd(4'h5, 2'h0, 1'b0, 16'h0000);
    cmp(16'hA5C3, src_operand_r);
    rd(4'h5, 2'h0, 1'b1, 16'h0000);
    cmp(16'h00C3, src_operand_r);
    rd(4'h6, 2'h0, 1'b0, 16'h0000);
    cmp(16'h0034, src_operand_r);
    rd(CROU_IDX_CG, 2'h0, 1'b0, 16'h0000);
    cmp(16'h0000, src_operand_r);
    wr(4'h7, 16'h0100, 1'b0);
    for (int i = 0; i < 2; i++) begin
      rd(4'h7, 2'h3, i[0], 16'h0000);
      cmp(16'h0100 + 16'(2 * i), src_addr_r);
      src_upd = 1'b1;
      @(negedge clk);
      src_upd = 1'b0;
    end
    dst_mode = 1'b1;
    dst_reg = 4'h7;
    rd(4'h7, 2'h1, 1'b0, 16'h0010);
    cmp(16'h0113, src_addr_r);
    cmp(16'h0113, dst_addr_r);
    dst_reg = CROU_IDX_SR;
    @(negedge clk);
    cmp(16'h0010, dst_addr_r);
    dst_mode = 1'b0;
    @(negedge clk);
    cmp(16'h0000, dst_addr_r);
    irq_req = 1'b1;
    wr(CROU_IDX_SR, 16'h0008, 1'b1);
    @(negedge clk);
    cmp(16'h0000, {status_word_r[15:1], irq_accept_r});
    wr(CROU_IDX_SR, 16'h0008, 1'b0);
    @(negedge clk);
    cmp(16'h0001, {15'h0, irq_accept_r});
    flg(16'h7FFF, 16'h0001, 1'b0);
    cmp(16'h010C, status_word_r);
    flg(16'hFFFF, 16'h0001, 1'b0);
    cmp(16'h000B, status_word_r);
    flg(16'h0080, 16'h0080, 1'b1);
    cmp(16'h010B, status_word_r);
    test_select_pin = 1'b1;
    repeat (3) @(negedge clk);
    cmp(16'h001A, {11'h0, dbg_active_r, dbg_pins_r});
    test_select_pin = 1'b0;
    repeat (3) @(negedge clk);
    cmp(16'h0000, {15'h0, dbg_active_r});
    do_reset();
    wr(CROU_IDX_SR, 16'h0010, 1'b0);
    pc_adv = 1'b1;
    @(negedge clk);
    pc_adv = 1'b0;
    cmp(16'h0002, {14'h0, core_clk_en_r, exec_en_r});
    cmp(16'h0000, program_counter_r);
    do_reset();
    wr(CROU_IDX_SR, 16'h0020, 1'b0);
    cmp(16'h0000, {14'h0, core_clk_en_r, exec_en_r});
    print_verdict();
  end
endmodule : cpu_register_operand_unit_test
